// >>> core/anr_regs.sv
// Purpose: Autoneg ability register bank behind an Avalon-MM slave
// Assumes: One clock, synchronous active-low reset
// Notes: Expansion register is read-only at its reset value here
////////////////////////////////////////////////////////////////////////////
// Contract
// - Bit 10 pause advertise, writable, resets zero
// - Bit 9 T4 advertise, resets zero
// - Bits 8..5 technology advertise, writable, reset one
// - Forced mode ignores technology advertise bits
// - Bits 4..0 selector, writable, resets 00001
// - Partner bit 15 next page request
// - Partner bit 14 acknowledge
// - Partner bit 13 remote fault
// - Partner bits 11,10 asymmetric and symmetric pause
// - Partner bits 9..5 technology abilities
// - Partner bits 4..0 selector, resets zero
// - Bit 11 asymmetric pause, writable, resets zero
//
// Added by the designer: the Avalon-MM register port.
module anr_regs
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  input wire logic pageValid,
  input wire logic [15:0] pageWord,
  output logic [15:0] advWord,
  output logic opSpeed100,
  output logic opFullDuplex
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus request bundle

  anr_pkg::anr_req_t req;
  assign req = '{read: read, write: write, address: address,
                 writedata: writedata};

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == anr_pkg::IDX_ADV) || (a == anr_pkg::IDX_LPA)
      || (a == anr_pkg::IDX_EXP) || (a == anr_pkg::IDX_CTL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes answer at once, reads after RD_WAIT cycles

  logic [1:0] rdCnt_ff;
  logic [1:0] nxt_rdCnt;
  logic [31:0] rdData_ff;
  logic [31:0] nxt_rdData;
  logic [1:0] resp_ff;
  logic [1:0] nxt_resp;
  logic [15:0] lpaReg;
  logic [15:0] adv_ff;
  logic [15:0] nxt_adv;
  logic [15:0] ctl_ff;
  logic [15:0] nxt_ctl;
  logic rdDone;
  logic [15:0] wrMask;
  logic [15:0] rdVal;

  assign rdDone = req.read && (rdCnt_ff == anr_pkg::RD_WAIT);

  always_comb
  begin
    nxt_rdCnt = '0;
    if (req.read && !rdDone)
    begin
      nxt_rdCnt = rdCnt_ff + 2'h1;
    end
    case (req.address)
      anr_pkg::IDX_ADV: rdVal = adv_ff;
      anr_pkg::IDX_LPA: rdVal = lpaReg;
      anr_pkg::IDX_EXP: rdVal = anr_pkg::EXP_RST;
      anr_pkg::IDX_CTL: rdVal = ctl_ff;
      default: rdVal = 16'h0000;
    endcase
    nxt_rdData = rdData_ff;
    nxt_resp = resp_ff;
    if (req.read && rdCnt_ff == anr_pkg::RD_WAIT - 2'h1)
    begin
      nxt_rdData = {16'h0000, rdVal};
      nxt_resp = mapped(req.address) ? 2'h0 : 2'h2;
    end
    else if (req.write)
    begin
      nxt_resp = mapped(req.address) ? 2'h0 : 2'h2;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rdCnt_ff <= '0;
      rdData_ff <= '0;
      resp_ff <= '0;
    end
    else
    begin
      rdCnt_ff <= nxt_rdCnt;
      rdData_ff <= nxt_rdData;
      resp_ff <= nxt_resp;
    end
  end

  assign waitrequest = req.read && !rdDone;
  assign readdata = rdData_ff;
  assign response = req.write ? (mapped(req.address) ? 2'h0 : 2'h2)
    : resp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Advertisement and control registers

  assign wrMask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  always_comb
  begin
    nxt_adv = adv_ff;
    nxt_ctl = ctl_ff;
    if (req.write && req.address == anr_pkg::IDX_ADV)
    begin
      // Bits 15..12 of this word stay zero in this block
      nxt_adv = (adv_ff & ~(wrMask & anr_pkg::ADV_WMASK))
        | (req.writedata[15:0] & wrMask & anr_pkg::ADV_WMASK);
    end
    if (req.write && req.address == anr_pkg::IDX_CTL)
    begin
      nxt_ctl = (ctl_ff & ~wrMask) | (req.writedata[15:0] & wrMask & 16'h0007);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      adv_ff <= anr_pkg::ADV_RST;
      ctl_ff <= anr_pkg::CTL_RST;
    end
    else
    begin
      adv_ff <= nxt_adv;
      ctl_ff <= nxt_ctl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Partner capture and mode selection

  anr_pkg::anr_mode_t forceMode;
  anr_pkg::anr_mode_t opMode;
  logic [15:0] advOut;

  assign forceMode = '{forced: ctl_ff[anr_pkg::CTL_FORCE],
                       speed100: ctl_ff[anr_pkg::CTL_F100],
                       fullDuplex: ctl_ff[anr_pkg::CTL_FFD]};

  anr_lp_capture u_lp
  (
    .clock(clock),
    .rst_b(rst_b),
    .pageValid(pageValid),
    .pageWord(pageWord),
    .lpaReg(lpaReg)
  );

  anr_mode_sel u_mode
  (
    .advReg(adv_ff),
    .lpaReg(lpaReg),
    .forceMode(forceMode),
    .opMode(opMode)
  );

  // Technology bits are not offered while forced
  always_comb
  begin
    advOut = adv_ff;
    if (forceMode.forced)
    begin
      advOut = adv_ff & ~anr_pkg::ADV_TECH_MASK;
    end
  end

  assign advWord = advOut;
  assign opSpeed100 = opMode.speed100;
  assign opFullDuplex = opMode.fullDuplex;

endmodule

// >>> core/anr_pkg.sv
// Purpose: Shared constants and types for the autoneg ability registers
// Assumes: 16-bit registers, each on one 32-bit Avalon word
// Notes: Register indexes are word indexes; byte address is index * 4
package anr_pkg;

  localparam int ADDR_W = 4;
  // Register word indexes
  localparam logic [ADDR_W-1:0] IDX_ADV = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_LPA = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_EXP = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_CTL = 4'h8;

  // Reset values
  localparam logic [15:0] ADV_RST = 16'h01e1;
  localparam logic [15:0] LPA_RST = 16'h0000;
  localparam logic [15:0] EXP_RST = 16'h0004;
  localparam logic [15:0] CTL_RST = 16'h0000;

  // Writable bits of the advertisement register
  localparam logic [15:0] ADV_WMASK = 16'h0fff;
  // Field positions
  localparam int ADV_ASYM = 11;
  localparam int ADV_PAUSE = 10;
  localparam int ADV_T4 = 9;
  localparam int ADV_TECH_HI = 8;
  localparam int ADV_TECH_LO = 5;
  localparam int SEL_HI = 4;
  localparam logic [15:0] ADV_TECH_MASK = 16'h01e0;
  localparam int CTL_FORCE = 0;
  localparam int CTL_F100 = 1;
  localparam int CTL_FFD = 2;

  // Wait states before a read answers
  localparam logic [1:0] RD_WAIT = 2'h1;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
  } anr_req_t;

  typedef struct packed {
    logic forced;
    logic speed100;
    logic fullDuplex;
  } anr_mode_t;

endpackage

// >>> core/anr_mode_sel.sv
// Purpose: Choose operating speed and duplex from mode and abilities
// Assumes: Partner page bits follow the base page layout
// Notes: Highest common denominator when negotiating
module anr_mode_sel
(
  input wire logic [15:0] advReg,
  input wire logic [15:0] lpaReg,
  input anr_pkg::anr_mode_t forceMode,
  output anr_pkg::anr_mode_t opMode
);

  logic [3:0] common;

  always_comb
  begin
    common = advReg[anr_pkg::ADV_TECH_HI:anr_pkg::ADV_TECH_LO]
      & lpaReg[anr_pkg::ADV_TECH_HI:anr_pkg::ADV_TECH_LO];
    opMode = '0;
    if (forceMode.forced)
    begin
      opMode = forceMode;
    end
    else if (common[3])
    begin
      opMode.speed100 = 1'b1;
      opMode.fullDuplex = 1'b1;
    end
    else if (common[2])
    begin
      opMode.speed100 = 1'b1;
    end
    else if (common[1])
    begin
      opMode.fullDuplex = 1'b1;
    end
  end

endmodule

// >>> core/anr_lp_capture.sv
// Purpose: Hold the link partner ability word
// Assumes: pageValid pulses once per received base page
// Notes: Bus writes never reach this register
module anr_lp_capture
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pageValid,
  input wire logic [15:0] pageWord,
  output logic [15:0] lpaReg
);

  logic [15:0] lpa_ff;
  logic [15:0] nxt_lpa;

  always_comb
  begin
    nxt_lpa = lpa_ff;
    if (pageValid)
    begin
      // Bit 12 is reserved and reads zero
      nxt_lpa = pageWord & 16'hefff;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      lpa_ff <= anr_pkg::LPA_RST;
    end
    else
    begin
      lpa_ff <= nxt_lpa;
    end
  end

  assign lpaReg = lpa_ff;

endmodule

// >>> tb/anr_regs_props.sv
// Purpose: Port checks on the ability register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Bound into anr_regs
module anr_regs_props
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  input wire logic [15:0] advWord
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic advWr;
  assign advWr = write && address == anr_pkg::IDX_ADV;
  sequence rdWait;
    waitrequest ##1 !waitrequest;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_write_nowait: assert property (write |-> !waitrequest)
    else $error("write stalled");
  a_read_wait: assert property (read && !$past(read) |-> rdWait)
    else $error("read wait state wrong");
  a_read_upper: assert property (read && !waitrequest |->
    readdata[31:16] == 16'h0000) else $error("upper half not zero");
  a_unmapped_read: assert property (read && !waitrequest &&
    address == 4'h3 |-> response == 2'h2 && readdata == 32'h0)
    else $error("unmapped read answer wrong");
  a_adv_reset: assert property ($rose(rst_b) |-> advWord == 16'h01e1)
    else $error("advertisement reset wrong");
  a_sel_write: assert property (advWr && byteenable[0] |=>
    advWord[4:0] == $past(writedata[4:0])) else $error("selector");
  a_pause_write: assert property (advWr && byteenable[1] |=>
    advWord[11:9] == $past(writedata[11:9])) else $error("pause bits");
  a_adv_hold: assert property (!write |=> $stable(advWord))
    else $error("advertisement changed without write");
endmodule

bind anr_regs anr_regs_props i_props
(
  .clock(clock), .rst_b(rst_b), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .response(response),
  .advWord(advWord)
);

// >>> tb/anr_regs_tb.sv
// Purpose: Self-checking bench for the ability register bank
// Assumes: Reads answer after one wait state
// Notes: The test sequence and the timeout both end in wrap_up
module anr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic pageValid = 1'b0;
  logic [15:0] pageWord = 16'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  logic [15:0] advWord;
  logic opSpeed100;
  logic opFullDuplex;
  logic [31:0] rdData;
  logic [1:0] rdResp;
  logic [1:0] wrResp;
  int miscompares = 0;
  int samples_checked = 0;

  anr_regs i_dut
  (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .response(response),
    .pageValid(pageValid), .pageWord(pageWord), .advWord(advWord),
    .opSpeed100(opSpeed100), .opFullDuplex(opFullDuplex)
  );

  initial
  begin
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d,
    input logic [3:0] be);
    @(posedge clock);
    address <= a;
    writedata <= {16'h0000, d};
    byteenable <= be;
    write <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0)
      @(posedge clock);
    wrResp = response;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0)
      @(posedge clock);
    rdData = readdata;
    rdResp = response;
    read <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [3:0] a,
    input logic [15:0] exp);
    rd(a);
    chk(what, {16'h0000, exp}, rdData);
  endtask

  task automatic page(input logic [15:0] w);
    @(posedge clock);
    pageValid <= 1'b1;
    pageWord <= w;
    @(posedge clock);
    pageValid <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk("adv", anr_pkg::IDX_ADV, 16'h01e1);
    rdchk("partner", anr_pkg::IDX_LPA, 16'h0000);
    rdchk("expansion", anr_pkg::IDX_EXP, 16'h0004);
    $display("reset test done");
  endtask

  task automatic t_adv;
    wr(anr_pkg::IDX_ADV, 16'hffff, 4'hf);
    rdchk("adv ones", anr_pkg::IDX_ADV, 16'h0fff);
    wr(anr_pkg::IDX_ADV, 16'h0000, 4'h1);
    rdchk("adv lane", anr_pkg::IDX_ADV, 16'h0f00);
    wr(anr_pkg::IDX_ADV, 16'h01e1, 4'h3);
    $display("advertise test done");
  endtask

  task automatic t_forced;
    wr(anr_pkg::IDX_CTL, 16'h0007, 4'hf);
    @(posedge clock);
    chk("forced adv", 32'h1, {16'h0, advWord});
    chk("forced mode", 32'h3, {30'h0, opSpeed100, opFullDuplex});
    wr(anr_pkg::IDX_CTL, 16'h0000, 4'hf);
    $display("forced test done");
  endtask

  task automatic t_partner;
    page(16'hffff);
    rdchk("partner", anr_pkg::IDX_LPA, 16'hefff);
    wr(anr_pkg::IDX_LPA, 16'h0000, 4'hf);
    chk("partner wr resp", 32'h0, {30'h0, wrResp});
    rdchk("partner kept", anr_pkg::IDX_LPA, 16'hefff);
    page(16'h0081);
    rdchk("partner page", anr_pkg::IDX_LPA, 16'h0081);
    chk("mode", 32'h2, {30'h0, opSpeed100, opFullDuplex});
    page(16'h0041);
    @(posedge clock);
    chk("mode 10fd", 32'h1, {30'h0, opSpeed100, opFullDuplex});
    wr(anr_pkg::IDX_CTL, 16'h0001, 4'hf);
    @(posedge clock);
    chk("forced 10hd", 32'h0, {30'h0, opSpeed100, opFullDuplex});
    wr(anr_pkg::IDX_CTL, 16'h0000, 4'hf);
    wr(4'h3, 16'hffff, 4'hf);
    chk("unmapped wr resp", 32'h2, {30'h0, wrResp});
    rd(4'h3);
    chk("unmapped data", 32'h0, rdData);
    chk("unmapped resp", 32'h2, {30'h0, rdResp});
    $display("partner test done");
  endtask

  // Reset again in mid-run after the registers were changed
  task automatic t_rst2;
    wr(anr_pkg::IDX_ADV, 16'h0000, 4'h3);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    t_reset;
    chk("reset mode", 32'h0, {30'h0, opSpeed100, opFullDuplex});
  endtask

  task automatic wrap_up;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    t_reset;
    t_adv;
    t_forced;
    t_partner;
    t_rst2;
    wrap_up;
  end

  initial
  begin
    repeat (2000) @(posedge clock);
    miscompares++;
    wrap_up;
  end
endmodule
